// File: fast_pwm_sine_generator.sv
// Summary of operation
// - the lock flag rises a fixed lock time after the fast source starts; software polls it.
// - in pwm mode a compare match on channel a changes the level of the output pin.
// - the counter top comes from the top compare value, 0xFF after reset.
// - writing a nonzero prescaler selection starts the counter once locked with the fast source selected; it stays still until then.
// - reaching top raises an overflow event once every pwm period.
// - duty writes go to a buffer copied to the active compare only at overflow.
// - the prescaler divides the fast source, by 4 in the demonstrated setup.
// - the overflow raises an interrupt request only when its enable is set.
// - the output is high while count is below duty, low from match until wrap.
// - setting the prescaler reset bit clears the divider chain.
`timescale 1ns/1ns
module fast_pwm_sine_generator
    import pwm_pkg::*;
#(
    parameter int LOCK_CNT = LOCK_CYCLES
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic pllStart,
    input wire logic fastClockSelect,
    input wire pwm_pkg::ctrl_t ctrl,
    input wire logic [7:0] topCompare,
    input wire logic topWrite,
    input wire logic [7:0] dutyCompareA,
    input wire logic dutyWrite,
    output logic pllLocked,
    output logic pwmOutputA,
    output logic overflowIrq,
    output pwm_pkg::status_t status
);
    import pwm_pkg::*;

    // ************************************************************
    // lock timer
    // ************************************************************
    lock_state_t lockState;
    lock_state_t next_lockState;
    logic [31:0] lockCnt;
    logic [31:0] next_lockCnt;

    always_comb begin
        next_lockState = lockState;
        next_lockCnt = lockCnt;
        case (lockState)
            LOCK_IDLE: begin
                next_lockCnt = '0;
                if (pllStart) next_lockState = LOCK_WAIT;
            end
            LOCK_WAIT: begin
                next_lockCnt = lockCnt + 32'h1;
                if (!pllStart) next_lockState = LOCK_IDLE;
                else if (lockCnt == 32'(LOCK_CNT - 1)) next_lockState = LOCK_DONE;
            end
            LOCK_DONE: begin
                if (!pllStart) next_lockState = LOCK_IDLE;
            end
            default: next_lockState = LOCK_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            lockState <= LOCK_IDLE;
            lockCnt <= '0;
        end else begin
            lockState <= next_lockState;
            lockCnt <= next_lockCnt;
        end
    end

    assign pllLocked = (lockState == LOCK_DONE);

    // ************************************************************
    // prescaler
    // ************************************************************
    logic [3:0] prescSel;
    logic [3:0] next_prescSel;
    logic countTick;
    logic runEnable;

    always_comb begin
        next_prescSel = prescSel;
        if (ctrl.prescSelWrite) next_prescSel = ctrl.prescSel;
    end

    always_ff @(posedge mclk) begin
        if (!nrst) prescSel <= PRESC_OFF;
        else prescSel <= next_prescSel;
    end

    assign runEnable = fastClockSelect && pllLocked;

    // divider chain, sel 3 gives divide by 4
    presc_divider #(
        .W(PRESC_W)
    ) u_presc (
        .mclk(mclk),
        .nrst(nrst),
        .clearChain(ctrl.prescalerResetBit || !runEnable),
        .sel(prescSel),
        .tick(countTick)
    );

    // ************************************************************
    // counter, compare and output
    // ************************************************************
    logic [7:0] count;
    logic [7:0] next_count;
    logic [7:0] top;
    logic [7:0] next_top;
    logic [7:0] dutyBuf;
    logic [7:0] next_dutyBuf;
    logic [7:0] dutyActive;
    logic [7:0] next_dutyActive;
    logic pwmOut;
    logic next_pwmOut;
    logic ovf;
    logic next_ovf;
    logic atTop;

    assign atTop = (count == top);

    always_comb begin
        next_count = count;
        next_top = top;
        next_dutyBuf = dutyBuf;
        next_dutyActive = dutyActive;
        next_ovf = 1'b0;
        next_pwmOut = pwmOut;
        if (topWrite) next_top = topCompare;
        if (dutyWrite) next_dutyBuf = dutyCompareA;
        if (countTick) begin
            if (atTop) begin
                next_count = 8'h00;
                next_ovf = 1'b1;
                next_dutyActive = next_dutyBuf;
                next_pwmOut = (next_dutyBuf != 8'h00);
            end else begin
                next_count = count + 8'h01;
                if (count + 8'h01 == dutyActive) next_pwmOut = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            count <= 8'h00;
            top <= TOP_RESET;
            dutyBuf <= DUTY_RESET;
            dutyActive <= DUTY_RESET;
            pwmOut <= 1'b0;
            ovf <= 1'b0;
        end else begin
            count <= next_count;
            top <= next_top;
            dutyBuf <= next_dutyBuf;
            dutyActive <= next_dutyActive;
            pwmOut <= next_pwmOut;
            ovf <= next_ovf;
        end
    end

    assign pwmOutputA = pwmOut;
    assign overflowIrq = ovf && ctrl.ovfIntEnable;
    assign status = '{count: count, dutyActive: dutyActive, overflowFlag: ovf};

    // ************************************************************
    // assertions
    // ************************************************************
    // lock follows start
    a_lock_needs_start: assert property (@(posedge mclk) disable iff (!nrst)
        pllLocked |-> $past(pllStart))
        else $error("lock without start");
    a_stopped_no_count: assert property (@(posedge mclk) disable iff (!nrst)
        (prescSel == PRESC_OFF && $past(prescSel) == PRESC_OFF) |=> $stable(count))
        else $error("counter moved without prescaler");
    a_unlocked_still: assert property (@(posedge mclk) disable iff (!nrst)
        !pllLocked ##1 !pllLocked |-> !countTick)
        else $error("tick while unlocked");
    a_ovf_at_top: assert property (@(posedge mclk) disable iff (!nrst)
        ovf |-> count == 8'h00 && $past(count) == $past(top))
        else $error("bad overflow");
    a_duty_latch: assert property (@(posedge mclk) disable iff (!nrst)
        !ovf |-> $stable(dutyActive))
        else $error("duty changed off overflow");
    a_irq_gate: assert property (@(posedge mclk) disable iff (!nrst)
        overflowIrq |-> $past(countTick && atTop) && ctrl.ovfIntEnable)
        else $error("irq not gated");
    a_pwm_low_match: assert property (@(posedge mclk) disable iff (!nrst)
        (countTick && !atTop && count + 8'h01 == dutyActive) |=> !pwmOutputA)
        else $error("pin not low at match");
    a_pwm_level: assert property (@(posedge mclk) disable iff (!nrst)
        $past(countTick) && count != 8'h00 && count >= dutyActive |-> !pwmOutputA)
        else $error("pin high above duty");
    a_pwm_wrap_high: assert property (@(posedge mclk) disable iff (!nrst)
        $past(countTick && atTop) |-> pwmOutputA == (dutyActive != 8'h00))
        else $error("pin wrong after wrap");
    a_top_reset: assert property (@(posedge mclk)
        !nrst |=> top == TOP_RESET)
        else $error("top not reset");
    a_clear_chain: assert property (@(posedge mclk) disable iff (!nrst)
        ctrl.prescalerResetBit && prescSel > 4'h1 |=> !countTick)
        else $error("tick after chain clear");
    c_overflow: cover property (@(posedge mclk) disable iff (!nrst) ovf);
    c_irq: cover property (@(posedge mclk) disable iff (!nrst) overflowIrq);
    c_locked: cover property (@(posedge mclk) disable iff (!nrst) $rose(pllLocked));
    c_pwm_fall: cover property (@(posedge mclk) disable iff (!nrst) $fell(pwmOutputA));
endmodule

// File: pwm_pkg.sv
package pwm_pkg;
    // ************************************************************
    // clocking and timing
    // ************************************************************
    localparam int CLK_FREQ_HZ = 50000000;
    localparam int LOCK_TIME_MS = 100;
    localparam int LOCK_CYCLES = CLK_FREQ_HZ / 1000 * LOCK_TIME_MS;
    localparam int FAST_CLK_MHZ = 64;
    localparam int COUNTER_CLK_MHZ = 16;
    localparam int DEMO_PRESCALE = FAST_CLK_MHZ / COUNTER_CLK_MHZ;
    localparam int LOADER_ASM_CYCLES = 21;
    localparam int LOADER_C_CYCLES = 46;
    // ************************************************************
    // reset values and widths
    // ************************************************************
    localparam int DATA_W = 8;
    localparam logic [7:0] TOP_RESET = 8'hFF;
    localparam logic [7:0] DUTY_RESET = 8'h00;
    localparam int PRESC_W = 15;
    localparam logic [3:0] PRESC_OFF = 4'h0;

    typedef struct packed {
        logic [3:0] prescSel;
        logic prescSelWrite;
        logic prescalerResetBit;
        logic ovfIntEnable;
    } ctrl_t;

    typedef struct packed {
        logic [7:0] count;
        logic [7:0] dutyActive;
        logic overflowFlag;
    } status_t;

    typedef enum logic [1:0] {
        LOCK_IDLE = 2'b00,
        LOCK_WAIT = 2'b01,
        LOCK_DONE = 2'b10
    } lock_state_t;
endpackage

// File: presc_divider.sv
`timescale 1ns/1ns
module presc_divider #(
    parameter int W = 15
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic clearChain,
    input wire logic [3:0] sel,
    output logic tick
);
    logic [W-1:0] chain;
    logic [W-1:0] next_chain;
    logic next_tick;

    // low bits that must all be set for a tick at a rate of 2**(s-1)
    function automatic logic [W-1:0] lowMask(input logic [3:0] s);
        return (W'(1) << (s - 4'h1)) - W'(1);
    endfunction

    always_comb begin
        next_chain = chain + 1'b1;
        next_tick = 1'b0;
        if (clearChain || sel == 4'h0) begin
            next_chain = '0;
        end else if (sel == 4'h1) begin
            next_tick = 1'b1;
        end else begin
            // the chain restarts on every tick, so a new selection takes hold within one period
            next_tick = ((chain & lowMask(sel)) == lowMask(sel));
            if (next_tick) begin
                next_chain = '0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            chain <= '0;
            tick <= 1'b0;
        end else begin
            chain <= next_chain;
            tick <= next_tick;
        end
    end
endmodule

// File: rc_filter.sv
`timescale 1ns/1ns
module rc_filter (
    input wire logic mclk,
    input wire logic pinLevel,
    output logic [15:0] level
);
    // ************************************************************
    // first order low pass on the pin
    // ************************************************************
    // a shift of 6 stands in for the pole; coarse, but enough to smooth the pulse train
    initial level = 16'h0000;
    always @(posedge mclk) begin
        if (pinLevel) begin
            level <= level + ((16'hFFFF - level) >> 6);
        end else begin
            level <= level - (level >> 6);
        end
    end
endmodule

// File: fast_pwm_sine_generator_tb.sv
`timescale 1ns/1ns
module fast_pwm_sine_generator_tb;
    import pwm_pkg::*;
    localparam int LOCKN = 10;
    logic mclk, nrst, pllStart, fastClockSelect, topWrite;
    logic dutyWrite = 1'b0;
    ctrl_t ctrl;
    logic [7:0] topCompare, written, lastDuty;
    logic [7:0] dutyCompareA = 8'h00;
    logic pllLocked, pwmOutputA, overflowIrq, loaderOn;
    logic wroteOnce = 1'b0;
    status_t status;
    logic [15:0] filtLevel;
    logic [7:0] sineTable [4];
    int mismatches = 0;
    int checksDone = 0;
    int cycles = 0;
    int sinceOvf = 0;
    int idx = 0;
    int expInterval, skipOvf, n;

    fast_pwm_sine_generator #(.LOCK_CNT(LOCKN)) DUT (.mclk(mclk), .nrst(nrst),
        .pllStart(pllStart), .fastClockSelect(fastClockSelect), .ctrl(ctrl),
        .topCompare(topCompare), .topWrite(topWrite), .dutyCompareA(dutyCompareA),
        .dutyWrite(dutyWrite), .pllLocked(pllLocked), .pwmOutputA(pwmOutputA),
        .overflowIrq(overflowIrq), .status(status));
    rc_filter FILT (.mclk(mclk), .pinLevel(pwmOutputA), .level(filtLevel));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    function automatic int period(input int top, input int sel);
        return (top + 1) * (1 << (sel - 1));
    endfunction

    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
    endtask

    task automatic setPresc(input logic [3:0] s);
        @(posedge mclk) ctrl.prescSel <= s;
        ctrl.prescSelWrite <= 1'b1;
        @(posedge mclk) ctrl.prescSelWrite <= 1'b0;
    endtask

    // ************************************************************
    // monitors and sample loader
    // ************************************************************
    always @(negedge mclk) begin
        if (nrst) begin
            chk(pwmOutputA, status.count < status.dutyActive);
            chk(overflowIrq, status.overflowFlag & ctrl.ovfIntEnable);
            sinceOvf++;
            if (status.overflowFlag) begin
                if (skipOvf > 0) skipOvf--;
                else chk(sinceOvf, expInterval);
                if (wroteOnce) chk(status.dutyActive, written);
                // the filtered level follows the duty of the period just ended
                if (lastDuty == 8'h00) chk(filtLevel < 16'h0040, 1'b1);
                if (lastDuty == 8'hFF) chk(filtLevel > 16'hE000, 1'b1);
                lastDuty = status.dutyActive;
                sinceOvf = 0;
            end
        end else begin
            lastDuty = DUTY_RESET;
        end
    end

    // service lands two cycles after the overflow, far inside any interval
    always @(negedge mclk) begin
        if (nrst && loaderOn && status.overflowFlag) begin
            @(posedge mclk);
            dutyCompareA <= sineTable[idx];
            dutyWrite <= 1'b1;
            written = sineTable[idx];
            wroteOnce = 1'b1;
            idx = (idx == 3) ? 0 : idx + 1;
            @(posedge mclk);
            dutyWrite <= 1'b0;
        end
    end

    // hang guard: the whole sequence needs well under 8000 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles > 10000) begin
            mismatches++;
            close_out();
        end
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        nrst = 1'b0;
        pllStart = 1'b0;
        fastClockSelect = 1'b0;
        ctrl = '0;
        topCompare = 8'h00;
        topWrite = 1'b0;
        loaderOn = 1'b0;
        skipOvf = 100;
        expInterval = 0;
        void'($urandom(80));
        sineTable[0] = 8'h00;
        sineTable[1] = 8'($urandom);
        sineTable[2] = 8'($urandom);
        sineTable[3] = 8'hFF;
        cyc(5);
        nrst <= 1'b1;
        @(negedge mclk) chk(status, {8'h00, DUTY_RESET, 1'b0});
        chk(pllLocked, 1'b0);
        $display("test reset done");
        @(posedge mclk) pllStart <= 1'b1;
        n = 0;
        while (pllLocked !== 1'b1 && n < 100) begin
            @(posedge mclk);
            n++;
            #1;
        end
        chk(n, LOCKN + 1);
        @(posedge mclk) fastClockSelect <= 1'b1;
        topCompare <= 8'h07;
        topWrite <= 1'b1;
        @(posedge mclk) topWrite <= 1'b0;
        cyc(20);
        @(negedge mclk) chk(status.count, 8'h00);
        $display("test lock done");
        for (int s = 1; s <= 3; s++) begin
            @(posedge mclk) ctrl.ovfIntEnable <= (s != 2);
            skipOvf = 2;
            expInterval = period(7, s);
            setPresc(4'(s));
            cyc(4 * expInterval + 8);
        end
        $display("test prescaler done");
        @(posedge mclk) topCompare <= 8'hFF;
        topWrite <= 1'b1;
        loaderOn <= 1'b1;
        skipOvf = 2;
        expInterval = period(255, 3);
        @(posedge mclk) topWrite <= 1'b0;
        cyc(6 * 1024);
        $display("test sine done");
        @(posedge mclk) ctrl.prescalerResetBit <= 1'b1;
        skipOvf = 100;
        cyc(3);
        @(negedge mclk) n = status.count;
        cyc(30);
        @(negedge mclk) chk(status.count, n);
        @(posedge mclk) ctrl.prescalerResetBit <= 1'b0;
        pllStart <= 1'b0;
        cyc(2);
        @(negedge mclk) chk(pllLocked, 1'b0);
        n = status.count;
        cyc(20);
        @(negedge mclk) chk(status.count, n);
        $display("test stop done");
        close_out();
    end
endmodule
